/* core/lp_reset_unit.sv */
// Stop/wait low-power control, stop recovery counter and reset-source status.
// Assumes reset causes are held stable by the reset generator until the first clock edge after reset release.
//
// Contract
// RL1: Stop entry resets counter, stops system clocks
// RL2: Interrupt ends stop after full recovery delay
// RL3: Reset or break also exits stop
// RL4: Clock generator output gated in stop
// RL5: Recovery 4096 cycles, or 32 if short
// RL6: Software keeps short recovery clear with crystal
// RL7: Break during stop sets break-exit flag
// RL8: Counter held reset until recovery begins
// RL9: Exit condition is pin, interrupt or break
// RL10: Registers decoded at fe00, fe01, fe03
// RL11: Break-exit flag cleared by write zero, reset
// RL12: Reading reset-source register clears it
// RL13: Power-on sets its flag, clears others
// RL14: Separate flag for each reset cause
// RL15: Bad address flag only for fetches
// RL16: Monitor flag on blank vector entry
// RL17: Clear enable gates clears during break
// RL18: Wait stops CPU clocks, peripherals run
// RL19: Break during wait sets break-exit flag
// RL20: Counter re-enables clocks at terminal count
// RL21: Status flags raise no interrupt
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module lp_reset_unit #(
  parameter int long_recovery  = lp_reset_pkg::long_recovery_cycles,
  parameter int short_recovery = lp_reset_pkg::short_recovery_cycles
) (
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       pclk_unused_tie,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [15:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire lp_reset_pkg::reset_cause_t reset_cause,
  input  wire logic                       fetch_cycle,
  input  wire logic                       vector_blank,
  input  wire logic                       interrupt_one_pin,
  input  wire logic                       reset_pin_active,
  input  wire logic                       cpu_interrupt,
  input  wire logic                       break_interrupt,
  input  wire logic                       break_state,
  output logic                            clock_generator_output_en,
  output logic                            cpu_clock_en,
  output logic                            stack_start,
  output logic                            low_power_exit,
  output logic [1:0]                      power_mode
);
  localparam logic [12:0] long_term  = 13'(long_recovery - 1);
  localparam logic [12:0] short_term = 13'(short_recovery - 1);

  lp_reset_pkg::power_mode_t mode_reg;
  lp_reset_pkg::power_mode_t mode_next;
  logic [12:0] count_reg;
  logic        break_exit_flag_reg;
  logic        break_exit_flag_next;
  logic [7:0]  reset_status_reg;
  logic [7:0]  reset_status_next;
  logic        break_clear_enable_reg;
  logic        short_recovery_select_reg;
  logic        cause_capture_reg;
  logic [31:0] prdata_next;

  // Exact match of a register address
  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction : addr_hit

  // Bus decode
  wire access      = psel && penable;
  wire wr          = access && pwrite && pstrb[0];
  wire rd          = access && !pwrite;
  wire hit_bes     = addr_hit(paddr, lp_reset_pkg::break_exit_status_addr);        // see RL10
  wire hit_rss     = addr_hit(paddr, lp_reset_pkg::reset_source_status_addr);      // see RL10
  wire hit_bfc     = addr_hit(paddr, lp_reset_pkg::break_flag_clear_control_addr); // see RL10
  wire hit_opt     = addr_hit(paddr, lp_reset_pkg::option_addr);
  wire hit_pwr     = addr_hit(paddr, lp_reset_pkg::power_control_addr);
  wire setup_phase = psel && !penable;
  wire mapped      = hit_bes || hit_rss || hit_bfc || hit_opt || hit_pwr;
  wire clear_ok    = !break_state || break_clear_enable_reg;                // see RL17

  // Exit condition and recovery terminal count
  wire exit_cond   = reset_pin_active || cpu_interrupt || break_interrupt;  // see RL9 RL3
  wire [12:0] term = short_recovery_select_reg ? short_term : long_term;    // see RL5 RL6
  wire at_term     = count_reg == term;                                     // see RL20
  wire stop_req    = wr && hit_pwr && pwdata[lp_reset_pkg::stop_request_bit];
  wire wait_req    = wr && hit_pwr && pwdata[lp_reset_pkg::wait_request_bit];
  wire low_power   = mode_reg == lp_reset_pkg::mode_stop || mode_reg == lp_reset_pkg::mode_wait;
  wire break_exit  = low_power && break_interrupt;                          // see RL7 RL19

  // Mode sequencing
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      lp_reset_pkg::mode_run: begin
        if (stop_req) begin
          mode_next = lp_reset_pkg::mode_stop;                              // see RL1
        end else if (wait_req) begin
          mode_next = lp_reset_pkg::mode_wait;                              // see RL18
        end
      end
      lp_reset_pkg::mode_wait: begin
        if (exit_cond) begin
          mode_next = lp_reset_pkg::mode_run;
        end
      end
      lp_reset_pkg::mode_stop: begin
        if (exit_cond) begin
          mode_next = lp_reset_pkg::mode_recover;                           // see RL2 RL3
        end
      end
      lp_reset_pkg::mode_recover: begin
        if (at_term) begin
          mode_next = lp_reset_pkg::mode_run;                               // see RL20 RL2
        end
      end
      default: mode_next = lp_reset_pkg::mode_run;
    endcase
  end

  // Break-exit flag: set wins over a software clear
  always_comb begin
    break_exit_flag_next = break_exit_flag_reg;
    if (wr && hit_bes && !pwdata[lp_reset_pkg::break_exit_flag_bit] && clear_ok) begin
      break_exit_flag_next = 1'b0;                                          // see RL11 RL17
    end
    if (break_exit) begin
      break_exit_flag_next = 1'b1;                                          // see RL7 RL19 RL11
    end
  end

  // Reset-source flags: captured once after reset release, read clears
  always_comb begin
    reset_status_next = reset_status_reg;
    if (rd && hit_rss && clear_ok) begin
      reset_status_next = lp_reset_pkg::zero_byte_reset;                   // see RL12 RL17
    end
    if (cause_capture_reg) begin
      if (reset_cause.power_on) begin
        reset_status_next = lp_reset_pkg::power_on_status_reset;            // see RL13
      end else begin
        reset_status_next = reset_status_reg | {1'b0,                       // see RL14
          reset_cause.pin,
          reset_cause.watchdog,
          reset_cause.bad_opcode,
          reset_cause.bad_fetch_address && fetch_cycle,                     // see RL15
          1'b0,
          reset_cause.monitor_entry && vector_blank && interrupt_one_pin,   // see RL16
          reset_cause.low_voltage};
      end
    end
  end

  // Read data
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (hit_bes) begin
      prdata_next[lp_reset_pkg::break_exit_flag_bit] = break_exit_flag_reg;
    end else if (hit_rss) begin
      prdata_next[7:0] = reset_status_reg;
    end else if (hit_bfc) begin
      prdata_next[lp_reset_pkg::break_clear_enable_bit] = break_clear_enable_reg;
    end else if (hit_opt) begin
      prdata_next[lp_reset_pkg::short_recovery_select_bit] = short_recovery_select_reg;
    end else if (hit_pwr) begin
      prdata_next[1:0] = mode_reg;
    end
  end

  // Next values of the registered outputs
  wire clk_gen_next = mode_next != lp_reset_pkg::mode_stop &&
                      mode_next != lp_reset_pkg::mode_recover;             // see RL4 RL1
  wire cpu_clk_next = mode_next == lp_reset_pkg::mode_run;                 // see RL18
  wire stack_next   = mode_reg == lp_reset_pkg::mode_recover && at_term;   // see RL2
  wire in_recovery  = mode_reg == lp_reset_pkg::mode_recover;

  // Mode state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_reg <= lp_reset_pkg::mode_run;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Recovery counter, held clear outside recovery
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg <= 13'h0000;
    end else begin
      if (in_recovery) begin
        count_reg <= count_reg + 13'h0001;                                  // see RL8 RL20
      end else begin
        count_reg <= 13'h0000;                                              // see RL1 RL8
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      break_exit_flag_reg <= 1'b0;
    end else begin
      break_exit_flag_reg <= break_exit_flag_next;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reset_status_reg <= lp_reset_pkg::zero_byte_reset;
    end else begin
      reset_status_reg <= reset_status_next;
    end
  end

  // High for the first edge after reset release only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cause_capture_reg <= 1'b1;
    end else begin
      cause_capture_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      break_clear_enable_reg <= 1'b0;
    end else begin
      if (wr && hit_bfc) begin
        break_clear_enable_reg <= pwdata[lp_reset_pkg::break_clear_enable_bit];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      short_recovery_select_reg <= 1'b0;
    end else begin
      if (wr && hit_opt) begin
        short_recovery_select_reg <= pwdata[lp_reset_pkg::short_recovery_select_bit];
      end
    end
  end

  // Outputs, all registered; no interrupt output exists
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_next;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase && !mapped;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      clock_generator_output_en <= 1'b1;
    end else begin
      clock_generator_output_en <= clk_gen_next;                          // see RL4
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cpu_clock_en <= 1'b1;
    end else begin
      cpu_clock_en <= cpu_clk_next;                                       // see RL18
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stack_start <= 1'b0;
    end else begin
      stack_start <= stack_next;                                          // see RL2
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      low_power_exit <= 1'b0;
    end else begin
      low_power_exit <= exit_cond;                                        // see RL9 RL21
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      power_mode <= 2'b00;
    end else begin
      power_mode <= mode_next;
    end
  end
endmodule : lp_reset_unit
`default_nettype wire

/* include/lp_reset_pkg.sv */
// Package for the stop/wait and reset-status unit: register map, fields, timing.
// Assumes a 32-bit APB slave decoding byte addresses on the low address bits.
package lp_reset_pkg;
  localparam logic [15:0] break_exit_status_addr       = 16'hfe00;
  localparam logic [15:0] reset_source_status_addr     = 16'hfe01;
  localparam logic [15:0] break_flag_clear_control_addr = 16'hfe03;
  localparam logic [15:0] option_addr                  = 16'hfe08;
  localparam logic [15:0] power_control_addr           = 16'hfe0c;
  localparam int          break_exit_flag_bit          = 1;
  localparam int          break_clear_enable_bit       = 7;
  localparam int          short_recovery_select_bit    = 0;
  localparam int          stop_request_bit             = 0;
  localparam int          wait_request_bit             = 1;
  localparam logic [7:0]  zero_byte_reset              = 8'h00;
  localparam logic [7:0]  power_on_status_reset        = 8'h80;
  localparam int          long_recovery_cycles         = 4096;
  localparam int          short_recovery_cycles        = 32;

  typedef enum logic [1:0] {
    mode_run      = 2'b00,
    mode_wait     = 2'b01,
    mode_stop     = 2'b10,
    mode_recover  = 2'b11
  } power_mode_t;

  // Reset causes as reported in the reset-source register, bit 7 down to bit 0, bit 2 unused
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch_address;
    logic monitor_entry;
    logic low_voltage;
  } reset_cause_t;
endpackage : lp_reset_pkg

/* testbench/lp_reset_chk.sv */
// Port checker for the stop/wait and reset-status unit.
// Bound to lp_reset_unit; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module lp_reset_chk #(
  parameter int long_recovery  = lp_reset_pkg::long_recovery_cycles,
  parameter int short_recovery = lp_reset_pkg::short_recovery_cycles
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [15:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        reset_pin_active,
  input wire logic        cpu_interrupt,
  input wire logic        break_interrupt,
  input wire logic        clock_generator_output_en,
  input wire logic        cpu_clock_en,
  input wire logic        stack_start,
  input wire logic        low_power_exit,
  input wire logic [1:0]  power_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [12:0] rec_cnt;
  wire         any_exit = reset_pin_active | cpu_interrupt | break_interrupt;
  wire         mapped   = paddr inside {lp_reset_pkg::break_exit_status_addr,
                                        lp_reset_pkg::reset_source_status_addr,
                                        lp_reset_pkg::break_flag_clear_control_addr,
                                        lp_reset_pkg::option_addr,
                                        lp_reset_pkg::power_control_addr};
  wire         in_stop  = power_mode == lp_reset_pkg::mode_stop;
  wire         in_rec   = power_mode == lp_reset_pkg::mode_recover;
  wire         in_run   = power_mode == lp_reset_pkg::mode_run;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) rec_cnt <= 13'h0;
    else rec_cnt <= in_rec ? rec_cnt + 13'h1 : 13'h0;
  end
  exit_follow_a: assert property (low_power_exit == $past(any_exit))
    else $error("exit flag does not follow its sources");
  stop_gate_a: assert property (in_stop |-> !clock_generator_output_en && !cpu_clock_en)
    else $error("clocks run in stop");
  wait_clk_a: assert property (power_mode == lp_reset_pkg::mode_wait |-> clock_generator_output_en && !cpu_clock_en)
    else $error("wrong clocks in wait");
  run_clk_a: assert property (in_run |-> clock_generator_output_en && cpu_clock_en)
    else $error("clocks off in run");
  stop_exit_a: assert property (in_stop && any_exit |-> ##[1:3] in_rec)
    else $error("stop not left on exit source");
  rec_len_a: assert property (in_run && $past(in_rec) |-> rec_cnt == long_recovery || rec_cnt == short_recovery)
    else $error("recovery length wrong");
  stack_go_a: assert property (in_run && $past(in_rec) |-> ##[0:1] stack_start)
    else $error("no stacking pulse after recovery");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  addr_err_a: assert property (pready |-> pslverr == !mapped)
    else $error("error response on wrong address");
  cover property (in_rec);
  cover property (power_mode == lp_reset_pkg::mode_wait);
  cover property (pready && pslverr);
  cover property (stack_start);
endmodule : lp_reset_chk
bind lp_reset_unit lp_reset_chk #(.long_recovery(long_recovery), .short_recovery(short_recovery)) i_lp_reset_chk (.*);
`default_nettype wire

/* testbench/lp_reset_unit_test.sv */
// Self-checking bench for the stop/wait and reset-status unit.
// Drives the APB and status inputs directly; checker is bound in.
`timescale 1ns/1ns
`default_nettype none
module lp_reset_unit_test;
  logic                       clock, reset, psel, penable, pwrite, fc, vb, ip, rpa, ci, bi, bs;
  logic [15:0]                paddr;
  logic [31:0]                pwdata, prdata, rd, r, cnt;
  logic [3:0]                 pstrb;
  logic                       pready, pslverr, err, cge, cce, ss, lpe;
  logic [1:0]                 pm;
  lp_reset_pkg::reset_cause_t rc;
  int                         fails, num_checks, seed, n, k;
  localparam int              long_rec  = 16;
  localparam int              short_rec = 32;
  lp_reset_unit #(.long_recovery(long_rec), .short_recovery(short_rec)) i_lp_reset_unit (
    .clock(clock),
    .reset(reset), .pclk_unused_tie(1'b0), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_cause(rc), .fetch_cycle(fc), .vector_blank(vb),
    .interrupt_one_pin(ip), .reset_pin_active(rpa), .cpu_interrupt(ci), .break_interrupt(bi),
    .break_state(bs), .clock_generator_output_en(cge), .cpu_clock_en(cce), .stack_start(ss),
    .low_power_exit(lpe), .power_mode(pm));
  task end_sim;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int t;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    t = 0;
    @(posedge clock);
    while (pready !== 1'b1 && t < 20) begin
      t++;
      @(posedge clock);
    end
    if (t == 20) begin
      fails++;
      end_sim;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function logic [7:0] exp_rs(lp_reset_pkg::reset_cause_t c, logic [2:0] v);
    if (c.power_on) return 8'h80;
    return {1'b0, c.pin, c.watchdog, c.bad_opcode, c.bad_fetch_address & v[0], 1'b0,
            c.monitor_entry & v[1] & v[2], c.low_voltage};
  endfunction : exp_rs
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    end_sim;
  end
  initial begin
    seed = 32'h54083403;
    {reset, psel, penable, pwrite, fc, vb, ip, rpa, ci, bi, bs} = 11'h400;
    paddr = 16'h0; pwdata = 32'h0; pstrb = 4'hf; rc = '0;
    for (n = 0; n < 7; n++) begin
      r = $random(seed);
      if (n == 1) r[2:1] = 2'b11;
      @(posedge clock);
      reset <= 1'b1; rc <= lp_reset_pkg::reset_cause_t'(7'h1 << n);
      fc <= r[0]; vb <= r[1]; ip <= r[2];
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, 16'hfe01, 32'h0);
      chk("reset_source", {24'h0, exp_rs(rc, r[2:0])}, rd);
      apb(1'b0, 16'hfe01, 32'h0);
      chk("reset_source_reread", 32'h0, rd);
      apb(1'b0, 16'hfe00, 32'h0);
      chk("break_exit_after_reset", 32'h0, rd);
    end
    for (n = 0; n < 6; n++) begin
      apb(1'b1, 16'hfe08, {31'h0, n[0]});
      apb(1'b1, 16'hfe0c, 32'h1);
      @(negedge clock);
      chk("stop_mode", {30'h0, lp_reset_pkg::mode_stop}, {30'h0, pm});
      chk("stop_clock_gen", 32'h0, {31'h0, cge});
      @(posedge clock);
      {rpa, bi, ci} <= 3'h1 << (n / 2);
      @(posedge clock);
      {rpa, bi, ci} <= 3'h0;
      cnt = 0;
      for (k = 0; k < 6000; k++) begin
        @(negedge clock);
        if (pm === lp_reset_pkg::mode_recover) cnt++;
        else if (cnt > 0) break;
      end
      chk("recovery_length", n[0] ? short_rec : long_rec, cnt);
      apb(1'b0, 16'hfe00, 32'h0);
      chk("break_exit_stop", (n / 2 == 1) ? 32'h2 : 32'h0, rd);
      apb(1'b1, 16'hfe00, 32'h0);
      apb(1'b0, 16'hfe00, 32'h0);
      chk("break_exit_clear", 32'h0, rd);
    end
    apb(1'b1, 16'hfe0c, 32'h2);
    @(negedge clock);
    chk("wait_cpu_clock", 32'h0, {31'h0, cce});
    @(posedge clock);
    bi <= 1'b1;
    @(posedge clock);
    bi <= 1'b0; bs <= 1'b1;
    apb(1'b1, 16'hfe03, 32'h0);
    apb(1'b1, 16'hfe00, 32'h0);
    apb(1'b0, 16'hfe00, 32'h0);
    chk("break_exit_wait_kept", 32'h2, rd);
    apb(1'b1, 16'hfe03, 32'h80);
    apb(1'b1, 16'hfe00, 32'h0);
    apb(1'b0, 16'hfe00, 32'h0);
    chk("break_exit_cleared", 32'h0, rd);
    bs <= 1'b0;
    apb(1'b0, 16'hfe02, 32'h0);
    chk("unmapped_error", 32'h1, {31'h0, err});
    end_sim;
  end
endmodule : lp_reset_unit_test
`default_nettype wire
